// ---- jtp_tap_port.sv ----
// Test access port: TAP controller, instruction and data registers, debug access
//
// Function
// - Sample mode and data on test clock rise
// - No async test reset pin exists
// - Fuse off: pins released, controller held reset
// - Fuse on, disable clear: pull-ups, port on
// - Data output undriven outside shift states
// - Sixteen-state controller steered by mode level
// - Power-on reset starts in Test-Logic-Reset
// - Every shift register moves LSB first
// - Instruction shift outputs captured value 0x01
// - Instruction changes only in Update-IR or on entering Test-Logic-Reset
// - Data shift outputs values captured in Capture-DR
// - Latched data outputs change only in Update-DR, except control bits clear while debug is off
// - Five mode-high clocks reach Test-Logic-Reset
// - Instruction selects and controls the data register
// - Data scan directly after instruction update allowed
// - Codes 8 to B reach debug system
// - Break on flow change and single step
// - Four resources: program, data, or range
// - Debug needs fuse and no lock bits
// - Processor returns results through I/O location
// - Test-Logic-Reset selects identification instruction
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_port #(
  parameter logic [31:0] IDCODE   = 32'h1234_5671, // arbitrary identification value
  parameter int          LOCK_W   = 2
) (
  input  wire logic                     mclk,                  // 20 MHz system clock
  input  wire logic                     rst_n,                 // async reset, active low
  input  wire logic                     tck_pin,               // test clock pin
  input  wire logic                     tms_pin,               // mode select pin
  input  wire logic                     tdi_pin,               // test data in pin
  output logic                          tdo_out,               // test data out level
  output logic                          tdo_oe_n,              // low while driving data out
  output logic                          test_pins_claimed,     // pins serve test port, pulled high
  input  wire logic                     test_port_enable_fuse, // port fuse programmed
  input  wire logic                     debug_enable_fuse,     // debug fuse programmed
  input  wire logic [LOCK_W-1:0]        lock_bits,             // any set locks debug
  input  wire logic [jtp_pkg::BUS_AW-1:0] avs_address,         // word index
  input  wire logic                     avs_read,              // read request
  input  wire logic                     avs_write,             // write request
  input  wire logic [31:0]              avs_writedata,         // write data
  output logic [31:0]                   avs_readdata,          // read data
  output logic                          avs_waitrequest,       // stall
  input  wire logic [jtp_pkg::ADDR_W-1:0] cpu_pc,              // retiring address
  input  wire logic                     cpu_retire,            // instruction retires
  input  wire logic                     cpu_flow_change,       // program flow changed
  input  wire logic [jtp_pkg::ADDR_W-1:0] cpu_dm_addr,         // data access address
  input  wire logic                     cpu_dm_access,         // data access strobe
  output logic [jtp_pkg::INSN_W-1:0]    cpu_insn,              // instruction fed to core
  output logic                          cpu_insn_valid,        // one-cycle insn strobe
  output logic                          cpu_halt_req,          // halt request level
  output logic                          cpu_break              // break pulse
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [2:0]                      pin_s1;
  logic [2:0]                      pin_s2;
  logic                            tck_prev;
  logic                            tck_rise;
  logic                            tck_fall;
  logic                            tms_s;
  logic                            tdi_s;

  jtp_pkg::jtp_tap_state_t         state;
  jtp_pkg::jtp_tap_state_t         next_state;
  logic [jtp_pkg::IR_W-1:0]        ir_sh;
  logic [jtp_pkg::IR_W-1:0]        next_ir_sh;
  logic [jtp_pkg::IR_W-1:0]        ir;
  logic [jtp_pkg::IR_W-1:0]        next_ir;
  logic [jtp_pkg::DR_W-1:0]        dr_sh;
  logic [jtp_pkg::DR_W-1:0]        next_dr_sh;
  logic                            next_tdo_out;
  logic                            next_tdo_oe_n;
  logic                            next_claimed;

  logic [jtp_pkg::CFG_W-1:0]       brk_cfg;
  logic [jtp_pkg::CFG_W-1:0]       next_brk_cfg;
  logic [jtp_pkg::CTL_W-1:0]       dbg_ctl;
  logic [jtp_pkg::CTL_W-1:0]       next_dbg_ctl;
  logic [jtp_pkg::INSN_W-1:0]      next_cpu_insn;
  logic                            next_cpu_insn_valid;
  logic [jtp_pkg::COMM_W-2:0]      comm_data;
  logic [jtp_pkg::COMM_W-2:0]      next_comm_data;
  logic                            comm_dirty;
  logic                            next_comm_dirty;

  logic                            port_dis;
  logic                            next_port_dis;
  logic                            bus_ack;
  logic                            next_bus_ack;
  logic [31:0]                     next_readdata;

  logic                            port_on;
  logic                            debug_on;
  logic [jtp_pkg::IR_W-1:0]        eff_ir;
  logic                            bus_req;
  logic                            brk_hit;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic jtp_pkg::jtp_tap_state_t tap_next(
    input jtp_pkg::jtp_tap_state_t s,
    input logic                    m
  );
    case (s)
      jtp_pkg::TS_RESET:   tap_next = m ? jtp_pkg::TS_RESET   : jtp_pkg::TS_IDLE;
      jtp_pkg::TS_IDLE:    tap_next = m ? jtp_pkg::TS_SEL_DR  : jtp_pkg::TS_IDLE;
      jtp_pkg::TS_SEL_DR:  tap_next = m ? jtp_pkg::TS_SEL_IR  : jtp_pkg::TS_CAP_DR;
      jtp_pkg::TS_CAP_DR:  tap_next = m ? jtp_pkg::TS_EX1_DR  : jtp_pkg::TS_SH_DR;
      jtp_pkg::TS_SH_DR:   tap_next = m ? jtp_pkg::TS_EX1_DR  : jtp_pkg::TS_SH_DR;
      jtp_pkg::TS_EX1_DR:  tap_next = m ? jtp_pkg::TS_UPD_DR  : jtp_pkg::TS_PAU_DR;
      jtp_pkg::TS_PAU_DR:  tap_next = m ? jtp_pkg::TS_EX2_DR  : jtp_pkg::TS_PAU_DR;
      jtp_pkg::TS_EX2_DR:  tap_next = m ? jtp_pkg::TS_UPD_DR  : jtp_pkg::TS_SH_DR;
      jtp_pkg::TS_UPD_DR:  tap_next = m ? jtp_pkg::TS_SEL_DR  : jtp_pkg::TS_IDLE;
      jtp_pkg::TS_SEL_IR:  tap_next = m ? jtp_pkg::TS_RESET   : jtp_pkg::TS_CAP_IR;
      jtp_pkg::TS_CAP_IR:  tap_next = m ? jtp_pkg::TS_EX1_IR  : jtp_pkg::TS_SH_IR;
      jtp_pkg::TS_SH_IR:   tap_next = m ? jtp_pkg::TS_EX1_IR  : jtp_pkg::TS_SH_IR;
      jtp_pkg::TS_EX1_IR:  tap_next = m ? jtp_pkg::TS_UPD_IR  : jtp_pkg::TS_PAU_IR;
      jtp_pkg::TS_PAU_IR:  tap_next = m ? jtp_pkg::TS_EX2_IR  : jtp_pkg::TS_PAU_IR;
      jtp_pkg::TS_EX2_IR:  tap_next = m ? jtp_pkg::TS_UPD_IR  : jtp_pkg::TS_SH_IR;
      jtp_pkg::TS_UPD_IR:  tap_next = m ? jtp_pkg::TS_SEL_DR  : jtp_pkg::TS_IDLE;
      default:             tap_next = jtp_pkg::TS_RESET;
    endcase
  endfunction : tap_next

  // Scan length of the register picked by an instruction
  function automatic logic [jtp_pkg::LEN_W-1:0] dr_len(input logic [jtp_pkg::IR_W-1:0] op);
    case (op)
      jtp_pkg::OP_IDCODE: dr_len = jtp_pkg::LEN_W'(jtp_pkg::ID_W);
      jtp_pkg::OP_DBG0:   dr_len = jtp_pkg::LEN_W'(jtp_pkg::CFG_W);
      jtp_pkg::OP_DBG1:   dr_len = jtp_pkg::LEN_W'(jtp_pkg::COMM_W);
      jtp_pkg::OP_DBG2:   dr_len = jtp_pkg::LEN_W'(jtp_pkg::INSN_W);
      jtp_pkg::OP_DBG3:   dr_len = jtp_pkg::LEN_W'(jtp_pkg::CTL_W);
      default:            dr_len = jtp_pkg::LEN_W'(1);
    endcase
  endfunction : dr_len

  function automatic logic is_dbg_op(input logic [jtp_pkg::IR_W-1:0] op);
    is_dbg_op = (op >= jtp_pkg::OP_DBG0) && (op <= jtp_pkg::OP_DBG3);
  endfunction : is_dbg_op

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Test pins are asynchronous to mclk; the test clock must stay well
  // below a quarter of mclk so that each edge is seen.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1   <= '0;
      pin_s2   <= '0;
      tck_prev <= 1'b0;
    end else begin
      pin_s1   <= {tck_pin, tms_pin, tdi_pin};
      pin_s2   <= pin_s1;
      tck_prev <= pin_s2[2];
    end
  end

  assign tms_s    = pin_s2[1];
  assign tdi_s    = pin_s2[0];
  assign tck_rise = pin_s2[2] & ~tck_prev;
  assign tck_fall = ~pin_s2[2] & tck_prev;

  // ----------------------------------------
  // Gating
  // ----------------------------------------
  assign port_on  = test_port_enable_fuse & ~port_dis;
  assign debug_on = debug_enable_fuse & ~(|lock_bits);
  // Locked parts see the debug codes as bypass, closing the back door
  assign eff_ir   = (is_dbg_op(ir) && !debug_on) ? jtp_pkg::OP_BYPASS : ir;
  assign bus_req  = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~bus_ack;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  always_comb begin
    logic [jtp_pkg::LEN_W-1:0] len;
    len                 = dr_len(eff_ir);
    next_state          = state;
    next_ir_sh          = ir_sh;
    next_ir             = ir;
    next_dr_sh          = dr_sh;
    next_tdo_out        = tdo_out;
    next_tdo_oe_n       = tdo_oe_n;
    next_claimed        = port_on;
    next_brk_cfg        = brk_cfg;
    next_dbg_ctl        = dbg_ctl;
    next_cpu_insn       = cpu_insn;
    next_cpu_insn_valid = 1'b0;
    next_comm_data      = comm_data;
    next_comm_dirty     = comm_dirty;
    next_port_dis       = port_dis;
    next_bus_ack        = bus_req & ~bus_ack;
    next_readdata       = avs_readdata;

    if (tck_rise) begin
      next_state = tap_next(state, tms_s);
      case (state)
        jtp_pkg::TS_CAP_IR: next_ir_sh = jtp_pkg::IR_CAPTURE;
        jtp_pkg::TS_SH_IR:  next_ir_sh = {tdi_s, ir_sh[jtp_pkg::IR_W-1:1]};
        jtp_pkg::TS_UPD_IR: next_ir = ir_sh;
        jtp_pkg::TS_CAP_DR: begin
          case (eff_ir)
            jtp_pkg::OP_IDCODE: next_dr_sh = jtp_pkg::DR_W'(IDCODE);
            jtp_pkg::OP_DBG0:   next_dr_sh = jtp_pkg::DR_W'(brk_cfg);
            jtp_pkg::OP_DBG1:   next_dr_sh = jtp_pkg::DR_W'({comm_dirty, comm_data});
            jtp_pkg::OP_DBG2:   next_dr_sh = jtp_pkg::DR_W'(cpu_insn);
            jtp_pkg::OP_DBG3:   next_dr_sh = jtp_pkg::DR_W'(dbg_ctl);
            default:            next_dr_sh = '0;
          endcase
        end
        jtp_pkg::TS_SH_DR: begin
          next_dr_sh            = dr_sh >> 1;
          next_dr_sh[len - 1'b1] = tdi_s;
        end
        jtp_pkg::TS_UPD_DR: begin
          case (eff_ir)
            jtp_pkg::OP_DBG0: next_brk_cfg = dr_sh[jtp_pkg::CFG_W-1:0];
            jtp_pkg::OP_DBG1: next_comm_dirty = 1'b0;
            jtp_pkg::OP_DBG2: begin
              next_cpu_insn       = dr_sh[jtp_pkg::INSN_W-1:0];
              next_cpu_insn_valid = 1'b1;
            end
            jtp_pkg::OP_DBG3: next_dbg_ctl = dr_sh[jtp_pkg::CTL_W-1:0];
            default: ;
          endcase
        end
        default: ;
      endcase
      if (next_state == jtp_pkg::TS_RESET) begin
        next_ir = jtp_pkg::OP_IDCODE;
      end
    end

    // Data out changes on the falling test clock edge
    if (tck_fall) begin
      next_tdo_out  = (state == jtp_pkg::TS_SH_IR) ? ir_sh[0] : dr_sh[0];
      next_tdo_oe_n = ~((state == jtp_pkg::TS_SH_IR) || (state == jtp_pkg::TS_SH_DR));
    end

    // Processor side of the debug mailbox and the port disable bit
    if (bus_req && !bus_ack) begin
      case (avs_address)
        jtp_pkg::REG_CTRL:   next_readdata = 32'(port_dis) << jtp_pkg::CTRL_DIS;
        jtp_pkg::REG_STATUS: next_readdata = (32'(state) << jtp_pkg::ST_STATE)
                                           | (32'(ir) << jtp_pkg::ST_IR)
                                           | (32'(debug_on) << jtp_pkg::ST_DBG)
                                           | (32'(test_pins_claimed) << jtp_pkg::ST_CLAIM)
                                           | (32'(cpu_halt_req) << jtp_pkg::ST_HALT)
                                           | (32'(cpu_break) << jtp_pkg::ST_BRK);
        jtp_pkg::REG_COMM:   next_readdata = 32'({comm_dirty, comm_data});
        default:             next_readdata = '0;
      endcase
    end
    if (avs_write && bus_ack) begin
      case (avs_address)
        jtp_pkg::REG_CTRL: next_port_dis = avs_writedata[jtp_pkg::CTRL_DIS];
        jtp_pkg::REG_COMM: begin
          // A processor write in the same cycle as a debugger read keeps dirty set
          next_comm_data  = avs_writedata[jtp_pkg::COMM_W-2:0];
          next_comm_dirty = 1'b1;
        end
        default: ;
      endcase
    end

    // Released pins: controller parked in reset, output not driven
    if (!port_on) begin
      next_state    = jtp_pkg::TS_RESET;
      next_ir       = jtp_pkg::OP_IDCODE;
      next_tdo_oe_n = 1'b1;
    end
    if (!debug_on) begin
      next_dbg_ctl = '0;
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  // Only the system reset clears these registers asynchronously; no test reset pin exists
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state             <= jtp_pkg::TS_RESET;
      ir_sh             <= jtp_pkg::IR_CAPTURE;
      ir                <= jtp_pkg::OP_IDCODE;
      dr_sh             <= '0;
      tdo_out           <= 1'b1;
      tdo_oe_n          <= 1'b1;
      test_pins_claimed <= 1'b0;
      brk_cfg           <= '0;
      dbg_ctl           <= '0;
      cpu_insn          <= '0;
      cpu_insn_valid    <= 1'b0;
      comm_data         <= '0;
      comm_dirty        <= 1'b0;
      port_dis          <= 1'b0;
      bus_ack           <= 1'b0;
      avs_readdata      <= '0;
    end else begin
      state             <= next_state;
      ir_sh             <= next_ir_sh;
      ir                <= next_ir;
      dr_sh             <= next_dr_sh;
      tdo_out           <= next_tdo_out;
      tdo_oe_n          <= next_tdo_oe_n;
      test_pins_claimed <= next_claimed;
      brk_cfg           <= next_brk_cfg;
      dbg_ctl           <= next_dbg_ctl;
      cpu_insn          <= next_cpu_insn;
      cpu_insn_valid    <= next_cpu_insn_valid;
      comm_data         <= next_comm_data;
      comm_dirty        <= next_comm_dirty;
      port_dis          <= next_port_dis;
      bus_ack           <= next_bus_ack;
      avs_readdata      <= next_readdata;
    end
  end

  assign cpu_halt_req = dbg_ctl[jtp_pkg::CTL_HALT];

  // ----------------------------------------
  // Break point unit
  // ----------------------------------------
  jtp_brk #(
    .AW (jtp_pkg::ADDR_W),
    .NR (jtp_pkg::NRES)
  ) u_brk (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .enable      (debug_on),
    .res_addr    (brk_cfg[jtp_pkg::CFG_EN_LSB-1:0]),
    .res_en      (brk_cfg[jtp_pkg::CFG_MODE_LSB-1:jtp_pkg::CFG_EN_LSB]),
    .mode        (brk_cfg[jtp_pkg::CFG_W-1:jtp_pkg::CFG_MODE_LSB]),
    .flow_en     (dbg_ctl[jtp_pkg::CTL_FLOW]),
    .step_en     (dbg_ctl[jtp_pkg::CTL_STEP]),
    .pc          (cpu_pc),
    .retire      (cpu_retire),
    .flow_change (cpu_flow_change),
    .dm_addr     (cpu_dm_addr),
    .dm_access   (cpu_dm_access),
    .brk_hit     (brk_hit)
  );

  assign cpu_break = brk_hit;

endmodule : jtp_tap_port
`default_nettype wire

// ---- jtp_pkg.sv ----
// Shared constants and types of the test access port block
`default_nettype none
package jtp_pkg;

  // ----------------------------------------
  // Instruction register
  // ----------------------------------------
  localparam int          IR_W       = 4;
  localparam logic [3:0]  IR_CAPTURE = 4'h1;
  localparam logic [3:0]  OP_IDCODE  = 4'h1;
  localparam logic [3:0]  OP_BYPASS  = 4'hF;
  localparam logic [3:0]  OP_DBG0    = 4'h8;
  localparam logic [3:0]  OP_DBG1    = 4'h9;
  localparam logic [3:0]  OP_DBG2    = 4'hA;
  localparam logic [3:0]  OP_DBG3    = 4'hB;

  // ----------------------------------------
  // Data register sizes and layouts
  // ----------------------------------------
  localparam int ADDR_W       = 16;
  localparam int NRES         = 4;
  localparam int MODE_W       = 3;
  localparam int CFG_EN_LSB   = NRES * ADDR_W;
  localparam int CFG_MODE_LSB = CFG_EN_LSB + NRES;
  localparam int CFG_W        = CFG_MODE_LSB + MODE_W;
  localparam int ID_W         = 32;
  localparam int COMM_W       = 8;
  localparam int INSN_W       = 16;
  localparam int CTL_W        = 3;
  localparam int DR_W         = CFG_W;
  localparam int LEN_W        = 7;
  localparam int CTL_HALT     = 0;
  localparam int CTL_FLOW     = 1;
  localparam int CTL_STEP     = 2;
  localparam int COMM_DIRTY   = 7;

  // ----------------------------------------
  // Register bus map
  // ----------------------------------------
  localparam int          BUS_AW      = 3;
  localparam logic [2:0]  REG_CTRL    = 3'h0;
  localparam logic [2:0]  REG_STATUS  = 3'h1;
  localparam logic [2:0]  REG_COMM    = 3'h2;
  localparam int          CTRL_DIS    = 0;
  localparam int          ST_STATE    = 0;
  localparam int          ST_IR       = 4;
  localparam int          ST_DBG      = 8;
  localparam int          ST_CLAIM    = 9;
  localparam int          ST_HALT     = 10;
  localparam int          ST_BRK      = 11;

  typedef enum logic [MODE_W-1:0] {
    BRK_PM4, BRK_PM3_DM1, BRK_PM2_DM2, BRK_PM2_PMRANGE, BRK_PM2_DMRANGE
  } jtp_brk_mode_t;

  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PAU_DR,
    TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR,
    TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
  } jtp_tap_state_t;

endpackage : jtp_pkg
`default_nettype wire

// ---- jtp_brk.sv ----
// Break point unit: four address resources, flow change and single step
`timescale 1ns/1ps
`default_nettype none
module jtp_brk #(
  parameter int AW = jtp_pkg::ADDR_W,
  parameter int NR = jtp_pkg::NRES
) (
  input  wire logic                          mclk,        // system clock
  input  wire logic                          rst_n,       // async reset, active low
  input  wire logic                          enable,      // debug system allowed
  input  wire logic [NR*AW-1:0]              res_addr,    // resource addresses
  input  wire logic [NR-1:0]                 res_en,      // resource enables
  input  wire logic [jtp_pkg::MODE_W-1:0]    mode,        // resource arrangement
  input  wire logic                          flow_en,     // break on flow change
  input  wire logic                          step_en,     // single step break
  input  wire logic [AW-1:0]                 pc,          // retiring address
  input  wire logic                          retire,      // instruction retires
  input  wire logic                          flow_change, // flow change seen
  input  wire logic [AW-1:0]                 dm_addr,     // data access address
  input  wire logic                          dm_access,   // data access strobe
  output logic                               brk_hit      // one-cycle break pulse
);

  logic brk_hit_q;
  logic next_brk_hit;

  function automatic logic is_dm(input logic [jtp_pkg::MODE_W-1:0] m, input int i);
    case (m)
      jtp_pkg::BRK_PM3_DM1:     is_dm = (i == NR - 1);
      jtp_pkg::BRK_PM2_DM2:     is_dm = (i >= NR - 2);
      jtp_pkg::BRK_PM2_DMRANGE: is_dm = (i >= NR - 2);
      default:                  is_dm = 1'b0;
    endcase
  endfunction : is_dm

  // ----------------------------------------
  // Compare
  // ----------------------------------------
  always_comb begin
    logic          ranged;
    logic          hit;
    logic [AW-1:0] a;
    logic [AW-1:0] msk;
    logic [AW-1:0] x;
    a      = '0;
    x      = '0;
    ranged = (mode == jtp_pkg::BRK_PM2_PMRANGE) || (mode == jtp_pkg::BRK_PM2_DMRANGE);
    hit    = 1'b0;
    msk    = '0;
    for (int i = 0; i < NR; i++) begin
      a = res_addr[i*AW +: AW];
      x = is_dm(mode, i) ? dm_addr : pc;
      // Top resource becomes the mask of its partner in range modes
      if (ranged && i == NR - 2) begin
        msk = res_addr[(NR-1)*AW +: AW];
      end else begin
        msk = '0;
      end
      if (res_en[i] && !(ranged && i == NR - 1) && (((x ^ a) & ~msk) == '0)) begin
        hit = hit | (is_dm(mode, i) ? dm_access : retire);
      end
    end
    next_brk_hit = enable & (hit | (step_en & retire) | (flow_en & flow_change));
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      brk_hit_q <= 1'b0;
    end else begin
      brk_hit_q <= next_brk_hit;
    end
  end

  assign brk_hit = brk_hit_q;

endmodule : jtp_brk
`default_nettype wire

// ---- jtp_tap_port_props.sv ----
// Assertion checker of the test access port
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_port_props #(parameter int LOCK_W = 2) (
  input wire logic              mclk,                  // clock
  input wire logic              rst_n,                 // reset
  input wire logic              tck_pin,               // test clock
  input wire logic              tms_pin,               // mode
  input wire logic              tdo_oe_n,              // data enable
  input wire logic              test_pins_claimed,     // pins taken
  input wire logic              test_port_enable_fuse, // port fuse
  input wire logic              debug_enable_fuse,     // debug fuse
  input wire logic [LOCK_W-1:0] lock_bits,             // locks
  input wire logic              cpu_retire,            // retire
  input wire logic              cpu_dm_access,         // data access
  input wire logic              cpu_insn_valid,        // insn strobe
  input wire logic              cpu_halt_req,          // halt
  input wire logic              cpu_break              // break
);
  logic       tck_q;
  logic [1:0] hi_cnt;
  // Saturates at two mode-high rises; by then any shift has been left
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tck_q  <= 1'b0;
      hi_cnt <= 2'h0;
    end else begin
      tck_q <= tck_pin;
      if (tck_pin && !tck_q) hi_cnt <= tms_pin ? (hi_cnt | {hi_cnt[0], 1'b1}) : 2'h0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_fuse_off_float: assert property (!test_port_enable_fuse [*3] |-> tdo_oe_n)
    else $error("data out driven with fuse off");
  a_claim_drops: assert property (!test_port_enable_fuse |=> !test_pins_claimed)
    else $error("pins kept with fuse off");
  a_claim_needs_fuse: assert property ($rose(test_pins_claimed) |-> $past(test_port_enable_fuse))
    else $error("pins taken without fuse");
  a_oe_on_fall: assert property ($fell(tdo_oe_n) |-> !$past(tck_pin, 2) && !$past(tck_pin, 3))
    else $error("data out enabled off clock fall");
  a_mode_exit: assert property (hi_cnt == 2'h3 |-> tdo_oe_n)
    else $error("data out driven outside shift");
  a_debug_gated: assert property (cpu_halt_req || cpu_insn_valid |-> $past(debug_enable_fuse) && $past(lock_bits) == '0)
    else $error("debug active while disabled");
  a_break_cause: assert property (cpu_break |-> $past(cpu_retire) || $past(cpu_dm_access))
    else $error("break without cause");
  a_insn_pulse: assert property (cpu_insn_valid |=> !cpu_insn_valid)
    else $error("insn strobe too long");
endmodule : jtp_tap_port_props
bind jtp_tap_port jtp_tap_port_props #(.LOCK_W(LOCK_W)) u_props (.mclk, .rst_n, .tck_pin, .tms_pin,
  .tdo_oe_n, .test_pins_claimed, .test_port_enable_fuse, .debug_enable_fuse, .lock_bits, .cpu_retire,
  .cpu_dm_access, .cpu_insn_valid, .cpu_halt_req, .cpu_break);
`default_nettype wire

// ---- jtp_jtag_host.sv ----
// Model of the external test controller
`timescale 1ns/1ps
`default_nettype none
module jtp_jtag_host (
  output logic     tck_pin,  // test clock
  output logic     tms_pin,  // mode select
  output logic     tdi_pin,  // data to device
  input wire logic tdo_line  // pulled-up data line
);
  initial begin
    tck_pin = 1'b0;
    tms_pin = 1'b1;
    tdi_pin = 1'b1;
  end
  // Clock stands low between frames; data read before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms_pin = m;
    tdi_pin = d;
    #200 q = tdo_line;
    tck_pin = 1'b1;
    #200 tck_pin = 1'b0;
  endtask : step
  task automatic scan(input logic ir, input int n, input logic [79:0] di, output logic [79:0] dq);
    logic q;
    dq = '0;
    #7 step(1'b0, 1'b1, q);
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, di[i], q);
      dq[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : scan
  task automatic reset5;
    logic q;
    #7 repeat (5) step(1'b1, 1'b1, q);
  endtask : reset5
endmodule : jtp_jtag_host
`default_nettype wire

// ---- jtp_tap_port_tb.sv ----
// Self-checking testbench of the test access port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module jtp_tap_port_tb;
  localparam logic [31:0] ID_V = 32'h0BAD_F00D; // Arbitrary value
  logic mclk = 0, rst_n = 0, fuse = 1, dfuse = 1, rd = 0, wr = 0, ret = 0;
  logic [1:0] locks = 0;
  logic [2:0] adr = 0;
  logic [31:0] wdat = 0, q;
  logic [79:0] so;
  wire logic tck, tms, tdi, tdo, oe_n, claimed, wreq, hvalid, halt, brk, tdo_line;
  wire logic [15:0] insn;
  wire logic [31:0] rdat;
  int fail_count = 0, samples_checked = 0, brk_cnt = 0;
  assign tdo_line = oe_n ? 1'b1 : tdo;
  always #25 mclk = ~mclk;
  always @(posedge mclk) if (brk === 1'b1) brk_cnt++;
  jtp_tap_port #(.IDCODE(ID_V), .LOCK_W(2)) dut (.mclk(mclk), .rst_n(rst_n), .tck_pin(tck), .tms_pin(tms),
    .tdi_pin(tdi), .tdo_out(tdo), .tdo_oe_n(oe_n), .test_pins_claimed(claimed), .test_port_enable_fuse(fuse),
    .debug_enable_fuse(dfuse), .lock_bits(locks), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq), .cpu_pc(16'h0000), .cpu_retire(ret),
    .cpu_flow_change(1'b0), .cpu_dm_addr(16'h0000), .cpu_dm_access(1'b0), .cpu_insn(insn),
    .cpu_insn_valid(hvalid), .cpu_halt_req(halt), .cpu_break(brk));
  jtp_jtag_host host (.tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi), .tdo_line(tdo_line));
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    adr <= a; wdat <= d; rd <= !w; wr <= w;
    @(posedge mclk);
    while (wreq !== 1'b0 && n < 20) begin @(posedge mclk); n++; end
    if (n == 20) fail_count++;
    q = rdat;
    rd <= 1'b0; wr <= 1'b0;
  endtask : bus
  task automatic st(input logic [9:0] ex);
    bus(1'b0, 3'h1, 32'h0000_0000);
    `CHK("status", ex, q[9:0])
  endtask : st
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    #1_000_000 fail_count++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    st(10'h310);
    host.scan(1'b0, 32, 80'h0, so); `CHK("idcode", ID_V, so[31:0])
    host.scan(1'b1, 4, 80'hF, so); `CHK("ir capture", 4'h1, so[3:0])
    st(10'h3F1);
    host.scan(1'b0, 8, 80'hA5, so); `CHK("bypass", 8'h4A, so[7:0])
    $display("scan test done");
    host.scan(1'b1, 4, 80'hB, so);
    host.scan(1'b0, 3, 80'h5, so); `CHK("halt", 1'b1, halt)
    @(posedge mclk) ret <= 1'b1;
    @(posedge mclk) ret <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("break", 1'b1, brk_cnt != 0)
    host.scan(1'b1, 4, 80'hA, so);
    host.scan(1'b0, 16, 80'hBEEF, so); `CHK("insn", 16'hBEEF, insn)
    @(posedge mclk) locks <= 2'h1;
    repeat (3) @(posedge mclk);
    `CHK("locked halt", 1'b0, halt)
    st(10'h2A1);
    @(posedge mclk) locks <= 2'h0;
    $display("debug test done");
    host.reset5();
    st(10'h310);
    bus(1'b1, 3'h0, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    `CHK("claimed off", 1'b0, claimed)
    bus(1'b0, 3'h5, 32'h0000_0000); `CHK("unmapped", 32'h0000_0000, q)
    bus(1'b1, 3'h0, 32'h0000_0000);
    @(posedge mclk) fuse <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("fuse off", 1'b0, claimed)
    host.scan(1'b1, 4, 80'h3, so); `CHK("floating", 4'hF, so[3:0])
    $display("gate test done");
    conclude();
  end
endmodule : jtp_tap_port_tb
`default_nettype wire
